// ---- mem_pin_cfg.svh ----
// Constants for the dynamic memory pin interface
`ifndef MEM_PIN_CFG_SVH
`define MEM_PIN_CFG_SVH
`define DQ_W 16
`define ADDR_W 14
`define BANK_W 3
`define CS_NUM 2
`define STB_NUM 2
`define MASK_BEATS 4
// Row, column, write strobe codes (active low)
`define RCW_NOP 3'h7
`define RCW_ACT 3'h3
`define RCW_READ 3'h5
`define RCW_WRITE 3'h4
`define RCW_PRE 3'h2
`define RCW_REF 3'h1
`define RCW_LMR 3'h0
`define TMO_W 12
`define CLK_PERIOD_NS 25
`define RD_TIMEOUT_NS 2000
`define RD_TIMEOUT_CYC ((`RD_TIMEOUT_NS) / (`CLK_PERIOD_NS))
`endif

// ---- mem_pin_pkg.sv ----
// Types shared by the dynamic memory pin interface
`include "mem_pin_cfg.svh"
package mem_pin_pkg;
	typedef enum logic [2:0] {
		CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_LMR
	} mem_cmd_t;
	typedef struct packed {
		mem_cmd_t cmd;
		logic [`CS_NUM-1:0] cs;
		logic [`BANK_W-1:0] bank;
		logic [`ADDR_W-1:0] addr;
		logic [2*`DQ_W-1:0] wdata;
		logic [`MASK_BEATS-1:0] wmask;
	} mem_req_t;
	typedef struct packed {
		logic valid;
		logic err;
		logic [2*`DQ_W-1:0] data;
	} mem_rsp_t;
	typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_WDATA, ST_RDATA} ctl_state_t;
endpackage

// ---- pin_sync2.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module pin_sync2 #(
	parameter int W = 1
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end
	assign sync_o = sync_q;
endmodule

// ---- ddr_memory_pin_interface.sv ----
// Dynamic memory pin interface: command, clock, strobe and data pins
`timescale 1ns/100ps
`include "mem_pin_cfg.svh"
module ddr_memory_pin_interface #(
	parameter int RD_TMO = `RD_TIMEOUT_CYC
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	input wire mem_pin_pkg::mem_req_t req_i,
	output logic req_ready_o,
	output mem_pin_pkg::mem_rsp_t rsp_o,
	input wire logic diff_strobe_en_i,
	input wire logic mem_is_ddr3_i,
	input wire logic mem_reset_req_i,
	input wire logic clk_en_req_i,
	input wire logic term_req_i,
	output logic mem_clk_out_o,
	output logic mem_clk_out_n_o,
	output logic mem_clk_en_o,
	output logic [`CS_NUM-1:0] mem_chip_sel_n_o,
	output logic mem_row_strobe_n_o,
	output logic mem_col_strobe_n_o,
	output logic mem_write_en_n_o,
	output logic [`BANK_W-1:0] mem_bank_sel_o,
	output logic [`ADDR_W-1:0] mem_addr_o,
	input wire logic [`DQ_W-1:0] mem_data_i,
	output logic [`DQ_W-1:0] mem_data_o,
	output logic mem_data_oe_o,
	output logic mem_wmask_lo_o,
	output logic mem_wmask_hi_o,
	input wire logic [`STB_NUM-1:0] mem_strobe_i,
	output logic [`STB_NUM-1:0] mem_strobe_o,
	output logic mem_strobe_oe_o,
	output logic [`STB_NUM-1:0] mem_strobe_n_o,
	output logic mem_strobe_n_oe_o,
	output logic mem_term_en_o,
	output logic mem_reset_out_n_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	function automatic logic [2:0] rcw_code(input mem_pin_pkg::mem_cmd_t c);
		unique case (c)
			mem_pin_pkg::CMD_ACT: rcw_code = `RCW_ACT;
			mem_pin_pkg::CMD_READ: rcw_code = `RCW_READ;
			mem_pin_pkg::CMD_WRITE: rcw_code = `RCW_WRITE;
			mem_pin_pkg::CMD_PRE: rcw_code = `RCW_PRE;
			mem_pin_pkg::CMD_REF: rcw_code = `RCW_REF;
			mem_pin_pkg::CMD_LMR: rcw_code = `RCW_LMR;
			default: rcw_code = `RCW_NOP;
		endcase
	endfunction

	mem_pin_pkg::ctl_state_t state_q, state_d;
	mem_pin_pkg::mem_req_t req_q, req_d;
	mem_pin_pkg::mem_rsp_t rsp_q, rsp_d;
	logic clk_q, clk_d, clk_n_q, ready_q, ready_d, take, stb_edge;
	logic [`CS_NUM-1:0] cs_n_q, cs_n_d;
	logic [2:0] rcw_q, rcw_d;
	logic [`BANK_W-1:0] bank_q, bank_d;
	logic [`ADDR_W-1:0] addr_q, addr_d;
	logic [`DQ_W-1:0] dq_q, dq_d, rd_lo_q, rd_lo_d;
	logic dq_oe_q, dq_oe_d, dqs_q, dqs_d, beat_q, beat_d;
	logic dm_lo_q, dm_lo_d, dm_hi_q, dm_hi_d;
	logic cke_q, odt_q, rst_n_q, stb_prev_q, dqs_n_q, dqs_n_oe_q;
	logic [`TMO_W-1:0] tmo_q, tmo_d;
	logic [`DQ_W+`STB_NUM-1:0] pin_sync;

	////////////////////////////////////////////////////////////////////
	// Pin input synchronisers and strobe edge finder
	pin_sync2 #(.W(`DQ_W + `STB_NUM)) pin_sync2_inst (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({mem_strobe_i, mem_data_i}),
		.sync_o(pin_sync)
	);
	assign stb_edge = pin_sync[`DQ_W] != stb_prev_q;

	////////////////////////////////////////////////////////////////////
	// Command and data sequencer
	assign take = req_valid_i && ready_q;
	assign clk_d = ~clk_q;

	always_comb begin
		state_d = state_q;
		req_d = req_q;
		rsp_d = '0;
		cs_n_d = cs_n_q;
		rcw_d = rcw_q;
		bank_d = bank_q;
		addr_d = addr_q;
		dq_d = dq_q;
		dq_oe_d = 1'b0;
		dqs_d = 1'b0;
		dm_lo_d = 1'b0;
		dm_hi_d = 1'b0;
		beat_d = beat_q;
		rd_lo_d = rd_lo_q;
		tmo_d = tmo_q;
		unique case (state_q)
			mem_pin_pkg::ST_IDLE: begin
				if (take) begin
					req_d = req_i;
					cs_n_d = ~req_i.cs;
					rcw_d = rcw_code(req_i.cmd);
					bank_d = req_i.bank;
					addr_d = req_i.addr;
					state_d = mem_pin_pkg::ST_CMD;
				end
			end
			mem_pin_pkg::ST_CMD: begin
				if (clk_q) begin
					cs_n_d = '1;
					rcw_d = `RCW_NOP;
					beat_d = 1'b0;
					tmo_d = RD_TMO[`TMO_W-1:0];
					if (req_q.cmd == mem_pin_pkg::CMD_WRITE) begin
						dq_d = req_q.wdata[`DQ_W-1:0];
						dq_oe_d = 1'b1;
						dqs_d = 1'b1;
						dm_lo_d = req_q.wmask[0];
						dm_hi_d = req_q.wmask[1];
						state_d = mem_pin_pkg::ST_WDATA;
					end else if (req_q.cmd == mem_pin_pkg::CMD_READ) begin
						state_d = mem_pin_pkg::ST_RDATA;
					end else begin
						state_d = mem_pin_pkg::ST_IDLE;
					end
				end
			end
			mem_pin_pkg::ST_WDATA: begin
				if (!beat_q) begin
					dq_d = req_q.wdata[2*`DQ_W-1:`DQ_W];
					dq_oe_d = 1'b1;
					dm_lo_d = req_q.wmask[2];
					dm_hi_d = req_q.wmask[3];
					beat_d = 1'b1;
				end else begin
					state_d = mem_pin_pkg::ST_IDLE;
				end
			end
			mem_pin_pkg::ST_RDATA: begin
				tmo_d = tmo_q - `TMO_W'(1);
				if (stb_edge && !beat_q) begin
					rd_lo_d = pin_sync[`DQ_W-1:0];
					beat_d = 1'b1;
				end else if (stb_edge) begin
					rsp_d.valid = 1'b1;
					rsp_d.data = {pin_sync[`DQ_W-1:0], rd_lo_q};
					state_d = mem_pin_pkg::ST_IDLE;
				end else if (tmo_q == '0) begin
					rsp_d.err = 1'b1;
					state_d = mem_pin_pkg::ST_IDLE;
				end
			end
		endcase
		ready_d = (state_d == mem_pin_pkg::ST_IDLE) && clk_d;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= mem_pin_pkg::ST_IDLE;
			req_q <= '0;
			rsp_q <= '0;
			ready_q <= 1'b0;
			clk_q <= 1'b0;
			clk_n_q <= 1'b1;
			cs_n_q <= '1;
			rcw_q <= `RCW_NOP;
			bank_q <= '0;
			addr_q <= '0;
			dq_q <= '0;
			dq_oe_q <= 1'b0;
			dqs_q <= 1'b0;
			dm_lo_q <= 1'b0;
			dm_hi_q <= 1'b0;
			beat_q <= 1'b0;
			rd_lo_q <= '0;
			tmo_q <= '0;
			stb_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			req_q <= req_d;
			rsp_q <= rsp_d;
			ready_q <= ready_d;
			clk_q <= clk_d;
			clk_n_q <= ~clk_d;
			cs_n_q <= cs_n_d;
			rcw_q <= rcw_d;
			bank_q <= bank_d;
			addr_q <= addr_d;
			dq_q <= dq_d;
			dq_oe_q <= dq_oe_d;
			dqs_q <= dqs_d;
			dm_lo_q <= dm_lo_d;
			dm_hi_q <= dm_hi_d;
			beat_q <= beat_d;
			rd_lo_q <= rd_lo_d;
			tmo_q <= tmo_d;
			stb_prev_q <= pin_sync[`DQ_W];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Clock enable, termination, memory reset and complement strobe pins
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cke_q <= 1'b0;
			odt_q <= 1'b0;
			rst_n_q <= 1'b1;
			dqs_n_q <= 1'b0;
			dqs_n_oe_q <= 1'b0;
		end else begin
			cke_q <= clk_en_req_i;
			odt_q <= term_req_i;
			rst_n_q <= !(mem_is_ddr3_i && mem_reset_req_i);
			dqs_n_q <= ~dqs_d & diff_strobe_en_i;
			dqs_n_oe_q <= dq_oe_d & diff_strobe_en_i;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign req_ready_o = ready_q;
	assign rsp_o = rsp_q;
	assign mem_clk_out_o = clk_q;
	assign mem_clk_out_n_o = clk_n_q;
	assign mem_clk_en_o = cke_q;
	assign mem_chip_sel_n_o = cs_n_q;
	assign {mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_en_n_o} = rcw_q;
	assign mem_bank_sel_o = bank_q;
	assign mem_addr_o = addr_q;
	assign mem_data_o = dq_q;
	assign mem_data_oe_o = dq_oe_q;
	assign mem_wmask_lo_o = dm_lo_q;
	assign mem_wmask_hi_o = dm_hi_q;
	assign mem_strobe_o = {`STB_NUM{dqs_q}};
	assign mem_strobe_oe_o = dq_oe_q;
	assign mem_strobe_n_o = {`STB_NUM{dqs_n_q}};
	assign mem_strobe_n_oe_o = dqs_n_oe_q;
	assign mem_term_en_o = odt_q;
	assign mem_reset_out_n_o = rst_n_q;

	////////////////////////////////////////////////////////////////////
	// Checks
	sequence write_burst;
		mem_data_oe_o [*2] ##1 !mem_data_oe_o;
	endsequence
	chk_clk_inverse: assert property (mem_clk_out_n_o == ~mem_clk_out_o)
		else $error("clock complement not inverse");
	chk_cs_nop: assert property (
		(rcw_q == `RCW_NOP) |-> (&mem_chip_sel_n_o))
		else $error("chip select asserted without command");
	chk_act_code: assert property (
		take && req_i.cmd == mem_pin_pkg::CMD_ACT |=>
		rcw_q == `RCW_ACT && mem_chip_sel_n_o == ~$past(req_i.cs))
		else $error("activate encoded wrong");
	chk_bank_drive: assert property (
		take |=> mem_bank_sel_o == $past(req_i.bank) ##1 $stable(mem_bank_sel_o))
		else $error("bank address not held with command");
	chk_lmr_bank: assert property (
		take && req_i.cmd == mem_pin_pkg::CMD_LMR |=>
		rcw_q == `RCW_LMR && mem_bank_sel_o == $past(req_i.bank))
		else $error("mode register load encoded wrong");
	chk_write_beats: assert property (
		take && req_i.cmd == mem_pin_pkg::CMD_WRITE |-> ##3 write_burst)
		else $error("write burst timing wrong");
	chk_mask_lane: assert property (
		take && req_i.cmd == mem_pin_pkg::CMD_WRITE |-> ##3
		mem_wmask_lo_o == $past(req_i.wmask[0], 3) ##1
		mem_wmask_hi_o == $past(req_i.wmask[3], 4))
		else $error("write mask lane wrong");
	chk_clk_en: assert property (mem_clk_en_o == $past(clk_en_req_i))
		else $error("clock enable not following request");
	chk_term_en: assert property (mem_term_en_o == $past(term_req_i))
		else $error("termination not following request");
	chk_single_strobe: assert property (
		!$past(diff_strobe_en_i) |-> !mem_strobe_n_oe_o && mem_strobe_n_o == '0)
		else $error("complement strobe driven in single-ended mode");
	chk_reset_type: assert property (
		!mem_is_ddr3_i |=> mem_reset_out_n_o)
		else $error("memory reset driven for non-DDR3");
endmodule

// ---- mem_dev_model.sv ----
// Behavioural dynamic memory answering on chip select 0
`timescale 1ns/100ps
`include "mem_pin_cfg.svh"
module mem_dev_model (
	input wire logic ck_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic [2:0] rcw_i,
	input wire logic [2:0] ba_i,
	input wire logic [13:0] a_i,
	input wire logic clk_i,
	input wire logic oe_i,
	input wire logic [15:0] wd_i,
	input wire logic [1:0] dm_i,
	input wire logic [31:0] rd_i,
	input wire logic [7:0] dly_i,
	input wire logic drop_i,
	output logic [15:0] dq_o,
	output logic [1:0] dqs_o,
	output logic [19:0] cmd_o,
	output logic [35:0] wr_o
);
	//////////////////////////////
	initial begin
		dq_o = 16'h0;
		dqs_o = 2'h0;
		cmd_o = 20'h0;
		wr_o = 36'h0;
	end
	// Commands taken only while selected and clocked
	always @(posedge ck_i) begin
		if (cke_i && !cs_n_i) begin
			cmd_o <= {rcw_i, ba_i, a_i};
			if (rcw_i == `RCW_READ) begin
				fork
					serve();
				join_none
			end
		end
	end
	// Beat and masks taken at each clk_i rising edge while oe_i is high
	always @(posedge clk_i) begin
		if (oe_i) begin
			wr_o <= {dm_i, wd_i, wr_o[35:18]};
		end
	end
	// Read beats with strobe, then the data inverted
	task automatic serve();
		#(dly_i);
		dq_o = rd_i[15:0];
		dqs_o = 2'h3;
		#100;
		if (!drop_i) begin
			dq_o = rd_i[31:16];
			dqs_o = 2'h0;
			#100;
		end
		dq_o = ~dq_o;
	endtask
endmodule

// ---- tb_ddr_memory_pin_interface.sv ----
// Testbench for the dynamic memory pin interface
`timescale 1ns/100ps
`include "mem_pin_cfg.svh"
module tb_ddr_memory_pin_interface;
	logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, req_valid_i = 1'b0;
	logic diff_strobe_en_i = 1'b0, mem_is_ddr3_i = 1'b0;
	logic mem_reset_req_i = 1'b0, clk_en_req_i = 1'b0, term_req_i = 1'b0;
	mem_pin_pkg::mem_req_t req_i = '0;
	mem_pin_pkg::mem_rsp_t rsp_o;
	logic req_ready_o, mem_clk_out_o, mem_clk_out_n_o, mem_clk_en_o;
	logic mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_en_n_o;
	logic mem_data_oe_o, mem_wmask_lo_o, mem_wmask_hi_o, mem_strobe_oe_o;
	logic mem_strobe_n_oe_o, mem_term_en_o, mem_reset_out_n_o, drop = 1'b0;
	logic [1:0] mem_chip_sel_n_o, mem_strobe_i, mem_strobe_o, mem_strobe_n_o;
	logic [1:0] m_dqs;
	logic [2:0] mem_bank_sel_o;
	logic [7:0] dly = 8'h1e;
	logic [13:0] mem_addr_o;
	logic [15:0] mem_data_i, mem_data_o, m_dq;
	logic [19:0] m_cmd;
	logic [31:0] rd = 32'h0;
	logic [35:0] m_wr;
	int fails = 0, compares = 0;
	//////////////////////////////
	assign mem_data_i = mem_data_oe_o ? mem_data_o : m_dq;
	assign mem_strobe_i = mem_strobe_oe_o ? mem_strobe_o : m_dqs;
	ddr_memory_pin_interface #(.RD_TMO(16)) ddr_memory_pin_interface_inst (
		.sys_clk_i, .sys_rst_i, .req_valid_i, .req_i, .req_ready_o, .rsp_o,
		.diff_strobe_en_i, .mem_is_ddr3_i, .mem_reset_req_i, .clk_en_req_i,
		.term_req_i, .mem_clk_out_o, .mem_clk_out_n_o, .mem_clk_en_o,
		.mem_chip_sel_n_o, .mem_row_strobe_n_o, .mem_col_strobe_n_o,
		.mem_write_en_n_o, .mem_bank_sel_o, .mem_addr_o, .mem_data_i,
		.mem_data_o, .mem_data_oe_o, .mem_wmask_lo_o, .mem_wmask_hi_o,
		.mem_strobe_i, .mem_strobe_o, .mem_strobe_oe_o, .mem_strobe_n_o,
		.mem_strobe_n_oe_o, .mem_term_en_o, .mem_reset_out_n_o);
	mem_dev_model mem_dev_model_inst (.ck_i(mem_clk_out_o),
		.cke_i(mem_clk_en_o), .cs_n_i(mem_chip_sel_n_o[0]),
		.rcw_i({mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_en_n_o}),
		.ba_i(mem_bank_sel_o), .a_i(mem_addr_o), .clk_i(sys_clk_i),
		.oe_i(mem_data_oe_o), .wd_i(mem_data_o),
		.dm_i({mem_wmask_hi_o, mem_wmask_lo_o}), .rd_i(rd), .dly_i(dly),
		.drop_i(drop), .dq_o(m_dq), .dqs_o(m_dqs), .cmd_o(m_cmd), .wr_o(m_wr));
	//////////////////////////////
	initial forever #12.5 sys_clk_i = ~sys_clk_i;
	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic send(input mem_pin_pkg::mem_cmd_t c, input logic [1:0] cs,
		input logic [2:0] ba, input logic [13:0] a, input logic [35:0] w);
		int n;
		req_i <= '{c, cs, ba, a, w[31:0], w[35:32]};
		req_valid_i <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 20);
		req_valid_i <= 1'b0;
		chk(n < 20, 1);
	endtask
	// Pin state while reset is held
	task automatic t_reset();
		chk({mem_chip_sel_n_o, mem_row_strobe_n_o, mem_col_strobe_n_o,
			mem_write_en_n_o, mem_clk_out_o, mem_clk_out_n_o, mem_clk_en_o,
			mem_term_en_o, mem_reset_out_n_o, mem_data_oe_o,
			mem_strobe_oe_o, req_ready_o}, 13'h1f48);
	endtask
	// Clock enable and termination follow requests, memory reset follows its request only for DDR3
	task automatic t_static();
		for (int i = 0; i < 4; i++) begin
			{mem_is_ddr3_i, mem_reset_req_i} <= i[1:0];
			clk_en_req_i <= i[0];
			term_req_i <= i[1];
			repeat (2) @(posedge sys_clk_i);
			chk({mem_reset_out_n_o, mem_clk_en_o, mem_term_en_o},
				{i != 3, i[0], i[1]});
		end
		mem_reset_req_i <= 1'b0;
	endtask
	// Plain command seen by the memory
	task automatic one_cmd(input mem_pin_pkg::mem_cmd_t c,
		input logic [2:0] rcw, input logic [2:0] ba, input logic f);
		send(c, 2'h1, ba, 14'h1a5 ^ ba, '0);
		repeat (4) @(posedge sys_clk_i);
		chk(f ? m_cmd : {m_cmd[19:17], 17'h0},
			{rcw, f ? {ba, 14'h1a5 ^ ba} : 17'h0});
	endtask
	// Write of two beats with masks in one strobe mode
	task automatic t_write(input logic df, input logic [35:0] w);
		diff_strobe_en_i <= df;
		repeat (2) @(posedge sys_clk_i);
		send(mem_pin_pkg::CMD_WRITE, 2'h1, 3'h5, 14'h2b1, w);
		repeat (3) @(posedge sys_clk_i);
		chk({mem_strobe_oe_o, mem_strobe_o}, 3'h7);
		repeat (3) @(posedge sys_clk_i);
		chk(m_wr, {w[35:34], w[31:16], w[33:32], w[15:0]});
		chk(m_cmd, {3'(`RCW_WRITE), 3'h5, 14'h2b1});
	endtask
	// Read answered by the memory, late, or not at all
	task automatic t_read(input logic [1:0] cs, input logic [7:0] d,
		input logic dr, input logic [31:0] v, input logic e);
		int n;
		dly <= d;
		drop <= dr;
		rd <= v;
		send(mem_pin_pkg::CMD_READ, cs, 3'h2, 14'h0040, '0);
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (rsp_o.valid !== 1'b1 && rsp_o.err !== 1'b1 && n < 60);
		if (e) chk({rsp_o.valid, rsp_o.err}, 2'h1);
		else chk({rsp_o.valid, rsp_o.err, rsp_o.data}, {2'h2, v});
	endtask
	// Clock pair watched while reset is released, complement strobes while the strobe is driven
	always @(negedge sys_clk_i) begin
		if (!sys_rst_i) begin
			chk(mem_clk_out_n_o, {~mem_clk_out_o});
			if (mem_strobe_oe_o) chk({mem_strobe_n_oe_o, mem_strobe_n_o},
				diff_strobe_en_i ? {1'b1, ~mem_strobe_o} : 3'h0);
		end
	end
	initial begin
		#300000;
		fails++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge sys_clk_i);
		t_reset();
		sys_rst_i <= 1'b0;
		@(posedge sys_clk_i);
		t_static();
		one_cmd(mem_pin_pkg::CMD_ACT, `RCW_ACT, 3'h1, 1'b1);
		one_cmd(mem_pin_pkg::CMD_PRE, `RCW_PRE, 3'h6, 1'b1);
		one_cmd(mem_pin_pkg::CMD_REF, `RCW_REF, 3'h0, 1'b0);
		one_cmd(mem_pin_pkg::CMD_LMR, `RCW_LMR, 3'h3, 1'b1);
		t_write(1'b1, 36'h6_a55a_1234);
		t_write(1'b0, 36'h9_0ff0_beef);
		t_read(2'h1, 8'h1e, 1'b0, 32'hc3a5_96e1, 1'b0);
		t_read(2'h1, 8'h82, 1'b0, 32'h0f1e_2d3c, 1'b0);
		t_read(2'h2, 8'h1e, 1'b0, 32'h7777_1111, 1'b1);
		t_read(2'h1, 8'h1e, 1'b1, 32'h4242_8181, 1'b1);
		report_and_stop();
	end
endmodule
